// ==== gam_alarm_menu.sv ====
// Front-panel menu, calibration sequencing and two-level alarm logic.
// Assumes conc, trouble and cal_done/cal_ok come from logic on mclk;
// key pins are asynchronous and are synchronised here.
//
// Summary of operation
// [RULE1] Select held two seconds opens menu
// [RULE2] Up/down step four units, LEL default
// [RULE3] Up/down cycle four decimal positions
// [RULE4] Up/down raise or lower full scale
// [RULE5] Select stores choice, advances item
// [RULE6] Calibration entry lights calibration lamp
// [RULE7] Yes shows live; select starts, waits
// [RULE8] Good/fail shown two seconds, then reading
// [RULE9] After zero: select spans, release exits
// [RULE10] Span reference flashes, keys adjust it
// [RULE11] After span: end message, then entry
// [RULE12] Latch off self-clears; on needs release
// [RULE13] Energize mode inverts relay contact sense
// [RULE14] First threshold 1 to 90 percent
// [RULE15] Second threshold 1 to 100 percent
// [RULE16] Direction: rising at/above, falling at/below
// [RULE17] Rising: band above sets, below releases
// [RULE18] Falling: band below sets, above releases
// [RULE19] Dwell 0 to 30 s, 1 s steps
// [RULE20] Condition must hold for dwell time
// [RULE21] Relay enable gates alarm contact output
// [RULE22] Group end item returns to menu
// [RULE23] One-second tick times press, message, dwell
`default_nettype none

module gam_alarm_menu #(
  parameter int TICK_CYC = gam_pkg::CLK_HZ * gam_pkg::TICK_S
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Key pins
  input wire gam_pkg::gam_keys_t key_pins,
  // Measurement source
  input wire logic [13:0] conc,
  input wire logic trouble,
  // Calibration engine
  output gam_pkg::gam_cal_t cal_cmd,
  input wire logic cal_done,
  input wire logic cal_ok,
  // Display
  output gam_pkg::gam_state_t menu_state,
  output logic [13:0] disp_val,
  output logic disp_flash,
  output logic [1:0] unit_sel,
  output logic [1:0] dp_sel,
  output logic calibration_lamp,
  output logic cal_good,
  // Alarms
  output logic [1:0] alarm,
  output logic [1:0] relay_closed
);
  import gam_pkg::*;

  gam_state_t st_r, st_nxt;
  logic idx_r, idx_nxt;
  logic [13:0] edit_r, item_val, lim_lo, lim_hi;
  logic wrap, commit, cal_go;
  logic [3:0] kmeta_r, ksync_r, kprev_r;
  logic [CYC_W-1:0] tick_cyc_r, ui_cyc_r;
  logic [1:0] ui_sec_r;
  logic [1:0] unit_r, dp_r;
  logic [13:0] fs_r, span_r;
  logic latch_r, energ_r, cal_ok_r, rdy_r;
  gam_alm_t alm_r [2];
  logic [31:0] rdata;

  // Key synchroniser; edges are taken from the second stage only
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      kmeta_r <= 4'h0;
      ksync_r <= 4'h0;
      kprev_r <= 4'h0;
    end else if (ce) begin
      kmeta_r <= key_pins;
      ksync_r <= kmeta_r;
      kprev_r <= ksync_r;
    end
  end

  wire logic [3:0] kpress = ksync_r & ~kprev_r;
  wire logic sel_p = kpress[3];
  wire logic up_p = kpress[2];
  wire logic dn_p = kpress[1];
  wire logic rel_p = kpress[0];
  wire logic sel_lvl = ksync_r[3];

  // Free-running second tick for alarm dwell
  wire logic sec_tick = (tick_cyc_r == CYC_W'(TICK_CYC - 1));
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) tick_cyc_r <= '0;
    else if (ce) tick_cyc_r <= sec_tick ? '0 : tick_cyc_r + 1'b1; // RULE23
  end

  // Interface second counter, restarted on each state change so that
  // the press and message intervals start on a whole second
  wire logic ui_clr = (st_nxt != st_r) || (st_r == ST_MEAS && !sel_lvl);
  wire logic ui_tick = (ui_cyc_r == CYC_W'(TICK_CYC - 1));
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ui_cyc_r <= '0;
      ui_sec_r <= 2'h0;
    end else if (ce) begin
      ui_cyc_r <= (ui_clr || ui_tick) ? '0 : ui_cyc_r + 1'b1; // RULE23
      if (ui_clr) ui_sec_r <= 2'h0;
      else if (ui_tick && ui_sec_r != 2'h3) ui_sec_r <= ui_sec_r + 2'h1;
    end
  end

  wire logic long_press = sel_lvl && (ui_sec_r >= 2'(LONG_PRESS_S)); // RULE1
  wire logic msg_over = (ui_sec_r >= 2'(MSG_S)); // RULE8

  // Menu sequencing
  always_comb begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    commit = 1'b0;
    cal_go = 1'b0;
    case (st_r)
      ST_MEAS: if (long_press) st_nxt = ST_MENU; // RULE1
      ST_MENU: begin
        if (sel_p) begin
          case (edit_r[1:0])
            2'h0: st_nxt = ST_UNIT;
            2'h1: st_nxt = ST_CAL_SEL;
            default: st_nxt = ST_LATCH;
          endcase
        end else if (rel_p) st_nxt = ST_MEAS;
      end
      ST_UNIT, ST_DP, ST_FS, ST_LATCH, ST_ENERG, ST_THR, ST_DIR, ST_DB,
      ST_DWELL: begin
        if (sel_p) begin
          commit = 1'b1; // RULE5
          st_nxt = gam_state_t'(st_r + 5'h01);
          if (st_r == ST_ENERG) idx_nxt = 1'b0;
        end
      end
      ST_RELAY: begin
        if (sel_p) begin
          commit = 1'b1; // RULE5
          idx_nxt = 1'b1;
          st_nxt = idx_r ? ST_AL_END : ST_THR;
        end
      end
      ST_SC_END, ST_AL_END: if (sel_p) st_nxt = ST_MENU; // RULE22
      ST_CAL_SEL: begin
        if (sel_p) begin
          idx_nxt = edit_r[0];
          st_nxt = (edit_r[1:0] == 2'h2) ? ST_MENU : ST_CAL_YN;
        end
      end
      ST_CAL_YN: begin
        if (sel_p) begin
          if (!edit_r[0]) st_nxt = ST_CAL_SEL;
          else st_nxt = idx_r ? ST_SPAN_REF : ST_CAL_LIVE; // RULE7
        end
      end
      ST_SPAN_REF: begin
        if (sel_p) begin
          commit = 1'b1; // RULE10
          st_nxt = ST_CAL_LIVE;
        end
      end
      ST_CAL_LIVE: begin
        if (sel_p) begin
          cal_go = 1'b1; // RULE7
          st_nxt = ST_CAL_WAIT;
        end
      end
      ST_CAL_WAIT: if (cal_done) st_nxt = ST_CAL_RES;
      ST_CAL_RES: if (msg_over) st_nxt = ST_CAL_SHOW; // RULE8
      ST_CAL_SHOW: begin
        if (sel_p && idx_r) st_nxt = ST_CAL_END; // RULE11
        else if (sel_p) begin
          idx_nxt = 1'b1; // RULE9
          st_nxt = ST_SPAN_REF;
        end else if (rel_p && !idx_r) st_nxt = ST_CAL_SEL; // RULE9
      end
      ST_CAL_END: if (sel_p) st_nxt = ST_CAL_SEL; // RULE11
      default: st_nxt = ST_MEAS;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= ST_MEAS;
      idx_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
    end
  end

  // Value shown when an item is entered
  always_comb begin
    case (st_nxt)
      ST_UNIT: item_val = {12'h000, unit_r};
      ST_DP: item_val = {12'h000, dp_r};
      ST_FS: item_val = fs_r;
      ST_SPAN_REF: item_val = span_r;
      ST_LATCH: item_val = {13'h0000, latch_r};
      ST_ENERG: item_val = {13'h0000, energ_r};
      ST_THR: item_val = alm_r[idx_nxt].thr;
      ST_DIR: item_val = {13'h0000, alm_r[idx_nxt].fall};
      ST_DB: item_val = alm_r[idx_nxt].db;
      ST_DWELL: item_val = {9'h000, alm_r[idx_nxt].dwell};
      ST_RELAY: item_val = {13'h0000, alm_r[idx_nxt].rly_en};
      default: item_val = 14'h0000;
    endcase
  end

  // Edit limits; percentage limits follow the current full scale
  wire logic [20:0] fs_w = {7'h00, fs_r};
  wire logic [20:0] pct_max = idx_r ? 21'(THR2_MAX_PCT) : 21'(THR1_MAX_PCT);
  wire logic [13:0] thr_hi = 14'((fs_w * pct_max) / 21'(PCT_DEN));
  wire logic [13:0] thr_lo_raw = 14'((fs_w * 21'(THR_MIN_PCT) + 21'(PCT_DEN - 1))
                                     / 21'(PCT_DEN));
  wire logic [13:0] thr_lo = (thr_lo_raw == 14'h0000) ? 14'h0001 : thr_lo_raw;
  wire logic [13:0] db_hi = 14'((fs_w * 21'(DB_MAX_PCT)) / 21'(PCT_DEN));

  always_comb begin
    lim_lo = 14'h0000;
    lim_hi = 14'h0001;
    wrap = 1'b1;
    case (st_r)
      ST_MENU, ST_CAL_SEL: lim_hi = 14'h0002;
      ST_UNIT, ST_DP: lim_hi = 14'h0003; // RULE2 RULE3
      ST_FS: begin
        lim_lo = FS_MIN; // RULE4
        lim_hi = FS_MAX;
        wrap = 1'b0;
      end
      ST_SPAN_REF: begin
        lim_lo = 14'h0001;
        lim_hi = fs_r;
        wrap = 1'b0;
      end
      ST_THR: begin
        lim_lo = thr_lo; // RULE14 RULE15
        lim_hi = thr_hi;
        wrap = 1'b0;
      end
      ST_DB: begin
        lim_hi = db_hi;
        wrap = 1'b0;
      end
      ST_DWELL: begin
        lim_hi = 14'(DWELL_MAX_S); // RULE19
        wrap = 1'b0;
      end
      default: lim_hi = 14'h0001;
    endcase
  end

  wire logic chg = (st_nxt != st_r) || (idx_nxt != idx_r);
  wire logic up_ok = up_p && (edit_r < lim_hi);
  wire logic dn_ok = dn_p && (edit_r > lim_lo);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) edit_r <= 14'h0000;
    else if (ce) begin
      if (chg) edit_r <= item_val;
      else if (up_ok) edit_r <= edit_r + 14'h0001; // RULE4 RULE19
      else if (dn_ok) edit_r <= edit_r - 14'h0001;
      else if (up_p && wrap) edit_r <= lim_lo; // RULE2 RULE3
      else if (dn_p && wrap) edit_r <= lim_hi;
    end
  end

  // APB: zero wait states once the setup cycle has been seen with ce high
  wire logic apb_done = psel && penable && pready;
  wire logic apb_wr = apb_done && pwrite;
  wire logic al_hit = (paddr >= REG_AL1_LVL) && (paddr <= REG_AL2_OPT);
  wire logic al_i = (paddr >= REG_AL2_LVL);
  wire logic mapped = (paddr[1:0] == 2'h0) && (paddr <= REG_STATUS);
  assign pready = penable && rdy_r && ce;
  assign pslverr = pready && !mapped;

  always_comb begin
    rdata = 32'h0000_0000;
    case (paddr)
      REG_SCALE: begin
        rdata[1:0] = unit_r;
        rdata[F_DP +: 2] = dp_r;
        rdata[F_FS +: 14] = fs_r;
      end
      REG_MODE: rdata[1:0] = {energ_r, latch_r};
      REG_AL1_LVL, REG_AL2_LVL: begin
        rdata[13:0] = alm_r[al_i].thr;
        rdata[F_DB +: 14] = alm_r[al_i].db;
      end
      REG_AL1_OPT, REG_AL2_OPT: begin
        rdata[0] = alm_r[al_i].fall;
        rdata[F_RLY] = alm_r[al_i].rly_en;
        rdata[F_DWELL +: 5] = alm_r[al_i].dwell;
      end
      REG_SPAN: rdata[13:0] = span_r;
      REG_STATUS: begin
        rdata[6:0] = {cal_ok_r, st_r == ST_CAL_WAIT, calibration_lamp,
                      relay_closed, alarm};
        rdata[F_ST +: 5] = st_r;
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdy_r <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      rdy_r <= psel && !apb_done;
      if (psel && !pwrite) prdata <= rdata;
    end
  end

  // Settings: a key commit lands after a bus write in the same cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      unit_r <= UNIT_LEL; // RULE2
      dp_r <= DP_RST;
      fs_r <= FS_RST;
      span_r <= SPAN_RST;
      latch_r <= 1'b0;
      energ_r <= 1'b0;
      alm_r[0] <= '{THR1_RST, DB_RST, 1'b0, 1'b1, DWELL_RST}; // RULE17
      alm_r[1] <= '{THR2_RST, DB_RST, 1'b0, 1'b1, DWELL_RST};
    end else if (ce) begin
      if (apb_wr && al_hit && !paddr[2]) begin
        alm_r[al_i].thr <= pwdata[13:0];
        alm_r[al_i].db <= pwdata[F_DB +: 14];
      end
      if (apb_wr && al_hit && paddr[2]) begin
        alm_r[al_i].fall <= pwdata[0];
        alm_r[al_i].rly_en <= pwdata[F_RLY];
        alm_r[al_i].dwell <= pwdata[F_DWELL +: 5];
      end
      if (apb_wr && paddr == REG_SCALE) begin
        unit_r <= pwdata[1:0];
        dp_r <= pwdata[F_DP +: 2];
        fs_r <= pwdata[F_FS +: 14];
      end
      if (apb_wr && paddr == REG_MODE) {energ_r, latch_r} <= pwdata[1:0];
      if (apb_wr && paddr == REG_SPAN) span_r <= pwdata[13:0];
      if (commit) begin
        case (st_r)
          ST_UNIT: unit_r <= edit_r[1:0]; // RULE5
          ST_DP: dp_r <= edit_r[1:0];
          ST_FS: fs_r <= edit_r;
          ST_SPAN_REF: span_r <= edit_r; // RULE10
          ST_LATCH: latch_r <= edit_r[0];
          ST_ENERG: energ_r <= edit_r[0];
          ST_THR: alm_r[idx_r].thr <= edit_r;
          ST_DIR: alm_r[idx_r].fall <= edit_r[0]; // RULE16
          ST_DB: alm_r[idx_r].db <= edit_r;
          ST_DWELL: alm_r[idx_r].dwell <= edit_r[4:0]; // RULE19
          ST_RELAY: alm_r[idx_r].rly_en <= edit_r[0];
          default: latch_r <= latch_r;
        endcase
      end
    end
  end

  // Calibration handshake and display outputs
  wire logic in_cal = (st_r >= ST_CAL_SEL) && (st_r <= ST_CAL_END);
  wire logic show_live = (st_r == ST_MEAS) || (st_r == ST_CAL_LIVE)
                         || (st_r == ST_CAL_SHOW);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cal_cmd <= '{1'b0, 1'b0, 14'h0000};
      cal_ok_r <= 1'b0;
      disp_val <= 14'h0000;
      disp_flash <= 1'b0;
      calibration_lamp <= 1'b0;
    end else if (ce) begin
      cal_cmd <= '{cal_go, idx_r, span_r}; // RULE7
      if (st_r == ST_CAL_WAIT && cal_done) cal_ok_r <= cal_ok; // RULE8
      disp_val <= show_live ? conc : edit_r; // RULE7
      disp_flash <= (st_r == ST_SPAN_REF); // RULE10
      calibration_lamp <= in_cal; // RULE6
    end
  end

  assign menu_state = st_r;
  assign unit_sel = unit_r;
  assign dp_sel = dp_r;
  assign cal_good = cal_ok_r;

  // Per-alarm hysteresis, dwell and relay drive
  for (genvar i = 0; i < 2; i++) begin : g_alm
    logic hys_r, alm_act_r, rly_r;
    logic [4:0] cnt_r;
    wire logic [14:0] band_hi = {1'b0, alm_r[i].thr} + {1'b0, alm_r[i].db};
    wire logic lo_ok = (alm_r[i].thr >= alm_r[i].db);
    wire logic [13:0] band_lo = lo_ok ? alm_r[i].thr - alm_r[i].db : 14'h0000;
    wire logic rise_set = ({1'b0, conc} >= band_hi); // RULE16 RULE17
    wire logic rise_clr = (conc < band_lo); // RULE17
    wire logic fall_set = lo_ok && (conc <= band_lo); // RULE16 RULE18
    wire logic fall_clr = ({1'b0, conc} > band_hi); // RULE18
    wire logic set_c = alm_r[i].fall ? fall_set : rise_set;
    wire logic clr_c = alm_r[i].fall ? fall_clr : rise_clr;
    // Tick phase is free, so one extra tick guarantees the full dwell
    wire logic due = hys_r && (alm_r[i].dwell == 5'h00 || cnt_r > alm_r[i].dwell);
    wire logic act = (alm_act_r && alm_r[i].rly_en) || trouble; // RULE21

    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        hys_r <= 1'b0;
        cnt_r <= 5'h00;
        alm_act_r <= 1'b0;
        rly_r <= 1'b0;
      end else if (ce) begin
        if (set_c) hys_r <= 1'b1;
        else if (clr_c) hys_r <= 1'b0;
        if (!hys_r) cnt_r <= 5'h00; // RULE20
        else if (sec_tick && !due) cnt_r <= cnt_r + 5'h01; // RULE20
        if (due) alm_act_r <= 1'b1; // RULE12
        else if (!latch_r || rel_p) alm_act_r <= 1'b0; // RULE12
        rly_r <= energ_r ? !act : act; // RULE13
      end
    end

    assign alarm[i] = alm_act_r;
    assign relay_closed[i] = rly_r;
  end

endmodule : gam_alarm_menu

`default_nettype wire

// ==== gam_pkg.sv ====
// Shared constants, types and register map of the gas alarm menu block.
// Assumes a single 20 MHz clock; key pins are asynchronous to it.
`default_nettype none

package gam_pkg;

  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_S = 1;
  localparam int LONG_PRESS_S = 2;
  localparam int MSG_S = 2;
  localparam int CYC_W = 25;

  // Setting limits
  localparam int DWELL_MAX_S = 30;
  localparam int THR_MIN_PCT = 1;
  localparam int THR1_MAX_PCT = 90;
  localparam int THR2_MAX_PCT = 100;
  localparam int DB_MAX_PCT = 10;
  localparam int PCT_DEN = 100;
  localparam logic [13:0] FS_MIN = 14'h0001;
  localparam logic [13:0] FS_MAX = 14'h270F;

  // Reset values
  localparam logic [1:0] UNIT_PPM = 2'h0;
  localparam logic [1:0] UNIT_LEL = 2'h3;
  localparam logic [1:0] DP_RST = 2'h0;
  localparam logic [13:0] FS_RST = 14'h0064;
  localparam logic [13:0] THR1_RST = 14'h0014;
  localparam logic [13:0] THR2_RST = 14'h0028;
  localparam logic [13:0] SPAN_RST = 14'h0032;
  localparam logic [13:0] DB_RST = 14'h0000;
  localparam logic [4:0] DWELL_RST = 5'h01;

  // Register byte offsets
  localparam logic [7:0] REG_SCALE = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h04;
  localparam logic [7:0] REG_AL1_LVL = 8'h08;
  localparam logic [7:0] REG_AL1_OPT = 8'h0C;
  localparam logic [7:0] REG_AL2_LVL = 8'h10;
  localparam logic [7:0] REG_AL2_OPT = 8'h14;
  localparam logic [7:0] REG_SPAN = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;

  // Field positions
  localparam int F_DP = 4;
  localparam int F_FS = 16;
  localparam int F_DB = 16;
  localparam int F_RLY = 1;
  localparam int F_DWELL = 8;
  localparam int F_ST = 8;

  typedef enum logic [4:0] {
    ST_MEAS, ST_MENU, ST_UNIT, ST_DP, ST_FS, ST_SC_END,
    ST_CAL_SEL, ST_CAL_YN, ST_SPAN_REF, ST_CAL_LIVE, ST_CAL_WAIT,
    ST_CAL_RES, ST_CAL_SHOW, ST_CAL_END,
    ST_LATCH, ST_ENERG, ST_THR, ST_DIR, ST_DB, ST_DWELL, ST_RELAY, ST_AL_END
  } gam_state_t;

  typedef struct packed {
    logic sel;
    logic up;
    logic down;
    logic rel;
  } gam_keys_t;

  typedef struct packed {
    logic start;
    logic span;
    logic [13:0] ref_val;
  } gam_cal_t;

  typedef struct packed {
    logic [13:0] thr;
    logic [13:0] db;
    logic fall;
    logic rly_en;
    logic [4:0] dwell;
  } gam_alm_t;

endpackage : gam_pkg

`default_nettype wire

// ==== gam_cal_model.sv ====
// Behavioural calibration engine facing the menu block's calibration port.
// Assumes the bench sets lag and pass before each start pulse.
`default_nettype none
module gam_cal_model
  import gam_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Command from the block
  input wire gam_pkg::gam_cal_t cmd,
  // Bench controls
  input wire logic [7:0] lag,
  input wire logic pass,
  // Result to the block
  output logic done,
  output logic res
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  logic junk;
  // Outcome line is only valid with done; otherwise it toggles
  assign res = done ? pass : junk;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      done <= 1'b0;
      junk <= 1'b0;
    end else begin
      done <= 1'b0;
      junk <= ~junk;
      if (cmd.start) begin
        cnt <= int'(lag);
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (cnt == 1) begin
        cnt <= 0;
        done <= 1'b1;
      end
    end
  end
endmodule : gam_cal_model
`default_nettype wire

// ==== gam_alarm_menu_props.sv ====
// Concurrent checks of the gas alarm menu block, bound to its top module.
// Assumes ce is held high and TICK_CYC matches the bound instance.
`default_nettype none
module gam_alarm_menu_props
  import gam_pkg::*;
#(
  parameter int TICK_CYC = 20
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Inputs of the block
  input wire logic penable,
  input wire gam_pkg::gam_keys_t key_pins,
  input wire logic trouble,
  input wire logic cal_done,
  input wire logic cal_ok,
  // Outputs of the block
  input wire logic pready,
  input wire logic pslverr,
  input wire gam_pkg::gam_cal_t cal_cmd,
  input wire gam_pkg::gam_state_t menu_state,
  input wire logic disp_flash,
  input wire logic calibration_lamp,
  input wire logic cal_good,
  input wire logic [1:0] relay_closed
);
  timeunit 1ns;
  timeprecision 1ps;
  int sel_cnt;
  int res_cnt;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sel_cnt <= 0;
      res_cnt <= 0;
    end else begin
      sel_cnt <= key_pins.sel ? sel_cnt + 1 : 0;
      res_cnt <= (menu_state == ST_CAL_RES) ? res_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence cal_finish;
    menu_state == ST_CAL_WAIT && cal_done;
  endsequence
  sequence res_left;
    $past(menu_state) == ST_CAL_RES && menu_state != ST_CAL_RES;
  endsequence
  err_ready_a: assert property (pslverr |-> pready && penable)
    else $error("error response without ready");
  long_press_a: assert property (
    $past(menu_state) == ST_MEAS && menu_state == ST_MENU |-> sel_cnt >= 2 * TICK_CYC)
    else $error("menu opened before a long select press");
  unit_next_a: assert property (
    $past(menu_state) == ST_UNIT && menu_state != ST_UNIT |-> menu_state == ST_DP)
    else $error("unit item did not advance to decimal item");
  lamp_on_a: assert property (
    menu_state inside {[ST_CAL_SEL:ST_CAL_END]} |=> calibration_lamp)
    else $error("calibration lamp dark in calibration");
  lamp_off_a: assert property (menu_state == ST_MEAS |=> !calibration_lamp)
    else $error("calibration lamp lit in measurement");
  start_wait_a: assert property (cal_cmd.start |-> menu_state == ST_CAL_WAIT)
    else $error("calibration start outside wait state");
  cal_result_a: assert property (
    cal_finish |=> menu_state == ST_CAL_RES && cal_good == $past(cal_ok))
    else $error("calibration outcome not shown");
  msg_len_a: assert property (
    res_left |-> menu_state == ST_CAL_SHOW && res_cnt >= 2 * TICK_CYC - 1
      && res_cnt <= 2 * TICK_CYC + 2)
    else $error("outcome message time wrong");
  span_flash_a: assert property (
    menu_state == ST_SPAN_REF ##1 menu_state == ST_SPAN_REF |-> disp_flash)
    else $error("reference value not flashing");
  group_end_a: assert property (
    $past(menu_state) inside {ST_SC_END, ST_AL_END} && menu_state != $past(menu_state)
      |-> menu_state == ST_MENU)
    else $error("end item left to a state other than menu");
  trouble_rly_a: assert property (
    trouble && $past(trouble) |-> relay_closed[0] == relay_closed[1])
    else $error("relays disagree during trouble");
endmodule : gam_alarm_menu_props
`default_nettype wire

// ==== gam_alarm_menu_bench.sv ====
// Self-checking bench of the gas alarm menu block with a calibration model.
// Assumes TICK_CYC shortened to 20 cycles; ce is held high throughout.
`default_nettype none
module gam_alarm_menu_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import gam_pkg::*;
  localparam int TICK_CYC = 20;
  logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, serr;
  logic trouble, cal_done, cal_ok, cal_pass, disp_flash, calibration_lamp, cal_good;
  logic [7:0] paddr, lag;
  logic [31:0] pwdata, prdata, rd;
  logic [13:0] conc, disp_val;
  logic [1:0] unit_sel, dp_sel, alarm, relay_closed;
  gam_keys_t key_pins;
  gam_cal_t cal_cmd;
  gam_state_t menu_state;
  int fails, checked, hys, i, n, c;
  gam_alarm_menu #(.TICK_CYC(TICK_CYC)) dut (.mclk(mclk), .rst_b(rst_b), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .key_pins(key_pins), .conc(conc),
    .trouble(trouble), .cal_cmd(cal_cmd), .cal_done(cal_done), .cal_ok(cal_ok),
    .menu_state(menu_state), .disp_val(disp_val), .disp_flash(disp_flash),
    .unit_sel(unit_sel), .dp_sel(dp_sel), .calibration_lamp(calibration_lamp),
    .cal_good(cal_good), .alarm(alarm), .relay_closed(relay_closed));
  gam_cal_model pm (.mclk(mclk), .rst_b(rst_b), .cmd(cal_cmd), .lag(lag), .pass(cal_pass),
    .done(cal_done), .res(cal_ok));
  task automatic close_out();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // The cyc, apb and press tasks start on a rising edge and return at a falling edge
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    @(negedge mclk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge mclk) penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    serr = pslverr;
    {psel, penable} <= 2'b00;
    @(negedge mclk);
  endtask : apb
  task automatic press(input logic [3:0] m);
    @(posedge mclk) key_pins <= gam_keys_t'(m);
    repeat (4) @(posedge mclk);
    key_pins <= '0;
    cyc(4);
  endtask : press
  task automatic wait_st(input gam_state_t s, input int lim);
    n = 0;
    while (menu_state !== s && n < lim) begin
      @(negedge mclk);
      n++;
    end
    chk(32'(menu_state), 32'(s));
  endtask : wait_st
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    #1_000_000;
    fails++;
    close_out();
  end
  initial begin
    {rst_b, psel, penable, pwrite, trouble, cal_pass} = 6'b000001;
    {paddr, pwdata, conc, key_pins} = '0;
    {fails, checked, hys} = 96'd1;
    lag = 8'h14;
    void'($urandom(26));
    cyc(10);
    @(posedge mclk) rst_b <= 1'b1;
    apb(0, REG_SCALE, '0);
    chk(rd, {2'h0, FS_RST, 10'h000, DP_RST, 2'h0, UNIT_LEL});
    apb(0, REG_AL1_LVL, '0);
    chk(rd, {2'h0, DB_RST, 2'h0, THR1_RST});
    apb(0, REG_AL2_OPT, '0);
    chk(rd, {19'h0, DWELL_RST, 8'h02});
    apb(0, 8'h20, '0);
    chk(rd, 32'h0);
    chk({31'h0, serr}, 32'h1);
    @(posedge mclk) key_pins <= gam_keys_t'(4'h8);
    cyc(TICK_CYC + 5);
    @(posedge mclk) key_pins <= '0;
    cyc(4);
    chk(32'(menu_state), 32'(ST_MEAS));
    @(posedge mclk) key_pins <= gam_keys_t'(4'h8);
    wait_st(ST_MENU, 2 * TICK_CYC + 10);
    chk(32'(n >= 2 * TICK_CYC), 32'h1);
    @(posedge mclk) key_pins <= '0;
    cyc(3);
    press(4'h8);
    press(4'h4);
    press(4'h4);
    press(4'h8);
    chk({30'h0, unit_sel}, 32'h1);
    chk(32'(menu_state), 32'(ST_DP));
    press(4'h2);
    press(4'h8);
    chk({30'h0, dp_sel}, 32'h3);
    press(4'h4);
    press(4'h4);
    press(4'h2);
    press(4'h8);
    apb(0, REG_SCALE, '0);
    chk({18'h0, rd[29:16]}, 32'(FS_RST) + 32'h1);
    press(4'h8);
    chk(32'(menu_state), 32'(ST_MENU));
    press(4'h4);
    press(4'h8);
    chk({30'h0, calibration_lamp, 32'(menu_state) == 32'(ST_CAL_SEL)}, 32'h3);
    press(4'h8);
    press(4'h4);
    press(4'h8);
    @(posedge mclk) conc <= 14'h0007;
    cyc(3);
    chk({18'h0, disp_val}, 32'h7);
    for (i = 0; i < 2; i++) begin
      cal_pass = (i == 0);
      press(4'h8);
      chk(32'(menu_state), 32'(ST_CAL_WAIT));
      wait_st(ST_CAL_RES, 40);
      chk({31'h0, cal_good}, 32'(i == 0));
      wait_st(ST_CAL_SHOW, 3 * TICK_CYC);
      press(4'h8);
      if (i == 0) begin
        chk({30'h0, disp_flash, 32'(menu_state) == 32'(ST_SPAN_REF)}, 32'h3);
        press(4'h4);
        press(4'h8);
        chk({17'h0, cal_cmd.span, cal_cmd.ref_val}, {18'h1, SPAN_RST + 14'h1});
      end
    end
    chk(32'(menu_state), 32'(ST_CAL_END));
    press(4'h8);
    chk(32'(menu_state), 32'(ST_CAL_SEL));
    // Mid-run reset must drop the lamp; only the lamp is checked
    @(posedge mclk) rst_b <= 1'b0;
    cyc(3);
    @(posedge mclk) {rst_b, conc} <= {1'b1, 14'h001E};
    cyc(1);
    chk({31'h0, calibration_lamp}, 32'h0);
    apb(1, REG_AL1_LVL, 32'h0002_0014);
    apb(1, REG_AL1_OPT, 32'h0000_0002);
    apb(1, REG_AL2_LVL, 32'h0000_000A);
    apb(1, REG_AL2_OPT, 32'h0000_0201);
    for (i = 0; i < 40; i++) begin
      c = int'($urandom_range(40, 11));
      @(posedge mclk) conc <= 14'(c);
      cyc(4);
      hys = (c >= 22) ? 1 : (c < 18) ? 0 : hys;
      chk({28'h0, alarm, relay_closed}, {28'h0, 1'b0, hys[0], 1'b0, hys[0]});
    end
    @(posedge mclk) conc <= 14'h000A;
    cyc(10);
    @(posedge mclk) conc <= 14'h0019;
    cyc(70);
    chk({31'h0, alarm[1]}, 32'h0);
    @(posedge mclk) conc <= 14'h000A;
    cyc(70);
    chk({28'h0, alarm, relay_closed}, 32'h8);
    apb(1, REG_MODE, 32'h0000_0003);
    @(posedge mclk) conc <= 14'h0019;
    cyc(70);
    chk({28'h0, alarm, relay_closed}, 32'hE);
    @(posedge mclk) conc <= 14'h000F;
    cyc(6);
    chk({30'h0, alarm}, 32'h3);
    press(4'h1);
    chk({31'h0, alarm[0]}, 32'h0);
    @(posedge mclk) trouble <= 1'b1;
    cyc(3);
    chk({30'h0, relay_closed}, 32'h0);
    close_out();
  end
endmodule : gam_alarm_menu_bench
bind gam_alarm_menu gam_alarm_menu_props #(.TICK_CYC(TICK_CYC)) props (.mclk(mclk),
  .rst_b(rst_b), .penable(penable), .key_pins(key_pins), .trouble(trouble),
  .cal_done(cal_done), .cal_ok(cal_ok), .pready(pready), .pslverr(pslverr),
  .cal_cmd(cal_cmd), .menu_state(menu_state), .disp_flash(disp_flash),
  .calibration_lamp(calibration_lamp), .cal_good(cal_good), .relay_closed(relay_closed));
`default_nettype wire
